// *** rtl/cmpirq_pkg.sv ***
// Purpose: constants shared by the comparator interrupt register block
// Assumes: 8-bit file-register addresses, 8-bit data
// Notes: offsets are file addresses, not byte addresses
package cmpirq_pkg;

  localparam int unsigned CMPIRQ_ADDR_W = 8;
  localparam int unsigned CMPIRQ_DATA_W = 8;

  // register offsets
  localparam logic [7:0] CMPIRQ_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] CMPIRQ_OFS_ENABLES = 8'h8c;
  localparam logic [7:0] CMPIRQ_OFS_CONTROL = 8'h0d;
  localparam logic [7:0] CMPIRQ_OFS_EVT_STATUS = 8'h0f;
  localparam logic [7:0] CMPIRQ_OFS_EVT_MASK = 8'h8f;

  // field positions
  localparam int unsigned CMPIRQ_CMP_BIT = 6;
  localparam int unsigned CMPIRQ_GIE_BIT = 7;
  localparam int unsigned CMPIRQ_EVT_BIT = 0;

  // values after reset
  localparam logic CMPIRQ_RST_FLAG = 1'b0;
  localparam logic CMPIRQ_RST_ENABLE = 1'b0;
  localparam logic CMPIRQ_RST_GIE = 1'b0;
  localparam logic CMPIRQ_RST_EVT = 1'b0;
  localparam logic CMPIRQ_RST_MASK = 1'b0;
  localparam logic [7:0] CMPIRQ_RST_RDATA = 8'h00;

endpackage

// *** rtl/cmpirq_regs.sv ***
// Purpose: comparator interrupt enable and flag registers with interrupt gating
// Assumes: comparator change arrives as a one-cycle pulse on core_clk
// Notes: read data appear in the cycle after the read strobe and only there
//
// Notes on behaviour
// - enable register holds comparator enable at bit 6; other bits read zero
// - flag register bit 6 sets on comparator change; other bits read zero
// - flag sets regardless of the individual and global enable bits
// - flag register decodes at file address 0Ch and clears at reset
`timescale 1ns/10ps

// register map, by file address
//   0x0c flags: bit 6 comparator change flag, set by hardware or by a write of 1
//   0x8c enables: bit 6 comparator request enable
//   0x0d control: bit 7 global request enable, a local stand-in for the core's own
//   0x0f event status: bit 0 sticky copy of the change, cleared by its own read
//   0x8f event mask: bit 0 lets the status drive the level interrupt
//   every other bit and every other address reads as zero
//
// timing
//   a write lands at the strobe edge; a read answers in the next cycle only
//   both requests are registered, one cycle behind the bits that feed them
//   the change pulse must already be on core_clk; there is no synchroniser here

module cmpirq_regs #(
  parameter int unsigned ADDR_W = cmpirq_pkg::CMPIRQ_ADDR_W,
  parameter int unsigned DATA_W = cmpirq_pkg::CMPIRQ_DATA_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire logic cmpChange,
  output logic cmpIrqReq,
  output logic irqOut
);

  // the register layout is fixed at one byte on an 8-bit file address
  if (ADDR_W != 8 || DATA_W != 8) begin : gen_bad_width
    $error("cmpirq_regs supports only 8-bit address and data");
  end

  typedef struct packed {
    logic flagBit;
    logic enableBit;
    logic globalEn;
    logic evtStatus;
    logic evtMask;
    logic [7:0] rdData;
    logic cmpIrq;
    logic irqLine;
  } cmpirq_state_t;

  cmpirq_state_t st;
  cmpirq_state_t next_st;

  logic hitFlags;
  logic hitEnables;
  logic hitControl;
  logic hitStatus;
  logic hitMask;

  // address decode for the five registers
  // only the full 8-bit address is compared; bank-mirrored copies of the
  // flag and enable registers are left to the core's own decode
  assign hitFlags = (regAddr == cmpirq_pkg::CMPIRQ_OFS_FLAGS);
  assign hitEnables = (regAddr == cmpirq_pkg::CMPIRQ_OFS_ENABLES);
  assign hitControl = (regAddr == cmpirq_pkg::CMPIRQ_OFS_CONTROL);
  assign hitStatus = (regAddr == cmpirq_pkg::CMPIRQ_OFS_EVT_STATUS);
  assign hitMask = (regAddr == cmpirq_pkg::CMPIRQ_OFS_EVT_MASK);

  // next-state logic: register writes, event capture, read mux, gating
  always_comb begin
    next_st = st;
    next_st.rdData = 8'h00;

    // software writes; hardware set below overrides a clear in the same cycle
    if (regWrite) begin
      if (hitFlags) begin
        next_st.flagBit = regWrData[cmpirq_pkg::CMPIRQ_CMP_BIT];
      end
      if (hitEnables) begin
        next_st.enableBit = regWrData[cmpirq_pkg::CMPIRQ_CMP_BIT];
      end
      if (hitControl) begin
        next_st.globalEn = regWrData[cmpirq_pkg::CMPIRQ_GIE_BIT];
      end
      if (hitMask) begin
        next_st.evtMask = regWrData[cmpirq_pkg::CMPIRQ_EVT_BIT];
      end
    end

    // read mux; unmapped addresses answer zero
    if (regRead) begin
      if (hitFlags) begin
        next_st.rdData[cmpirq_pkg::CMPIRQ_CMP_BIT] = st.flagBit;
      end
      if (hitEnables) begin
        next_st.rdData[cmpirq_pkg::CMPIRQ_CMP_BIT] = st.enableBit;
      end
      if (hitControl) begin
        next_st.rdData[cmpirq_pkg::CMPIRQ_GIE_BIT] = st.globalEn;
      end
      if (hitStatus) begin
        next_st.rdData[cmpirq_pkg::CMPIRQ_EVT_BIT] = st.evtStatus;
        next_st.evtStatus = 1'b0; // read clears the sticky status
      end
      if (hitMask) begin
        next_st.rdData[cmpirq_pkg::CMPIRQ_EVT_BIT] = st.evtMask;
      end
    end

    // comparator change wins over any clear so that no event is lost
    if (cmpChange) begin
      next_st.flagBit = 1'b1;
      next_st.evtStatus = 1'b1;
    end

    // request gating; registered so outputs come straight from flops
    // the extra flop costs one cycle of latency but keeps the request glitch free
    next_st.cmpIrq = st.flagBit & st.enableBit & st.globalEn;
    next_st.irqLine = st.evtStatus & st.evtMask;
  end

  // single state register, cleared asynchronously
  // every field is reset, so no unknown can leak into the requests
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st.flagBit <= cmpirq_pkg::CMPIRQ_RST_FLAG;
      st.enableBit <= cmpirq_pkg::CMPIRQ_RST_ENABLE;
      st.globalEn <= cmpirq_pkg::CMPIRQ_RST_GIE;
      st.evtStatus <= cmpirq_pkg::CMPIRQ_RST_EVT;
      st.evtMask <= cmpirq_pkg::CMPIRQ_RST_MASK;
      st.rdData <= cmpirq_pkg::CMPIRQ_RST_RDATA;
      st.cmpIrq <= 1'b0;
      st.irqLine <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign regRdData = st.rdData;
  assign cmpIrqReq = st.cmpIrq;
  assign irqOut = st.irqLine;

  // a stale flag would fire at once when enabled; software clears it first
  // (this block does not enforce that ordering)

  // the checks below watch the state copy and the ports together; they pause
  // during reset so that the forced clear does not count as a write
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_enable_readback: assert property (
    (regRead && hitEnables) |=> (regRdData == {1'b0, $past(st.enableBit), 6'h00}))
    else $error("enable register read back wrong");

  chk_flag_readback: assert property (
    (regRead && hitFlags) |=> (regRdData == {1'b0, $past(st.flagBit), 6'h00}))
    else $error("flag register read back wrong");

  chk_flag_sets_ungated: assert property (
    (cmpChange && !st.enableBit && !st.globalEn) |=> st.flagBit)
    else $error("flag not set while enables are off");

  chk_flag_write_clear: assert property (
    (regWrite && hitFlags && !regWrData[6] && !cmpChange) |=> !st.flagBit)
    else $error("flag not cleared by write at its address");

  chk_irq_gating: assert property (
    ##1 (cmpIrqReq == ($past(st.flagBit) && $past(st.enableBit) && $past(st.globalEn))))
    else $error("comparator request does not follow its gate");

  chk_irq_follows_event: assert property (
    (cmpChange && st.enableBit && st.globalEn && !regWrite) |=> ##1 cmpIrqReq)
    else $error("enabled change gave no request two cycles later");

  chk_status_read_clear: assert property (
    (regRead && hitStatus && !cmpChange) |=> !st.evtStatus ##1 !irqOut)
    else $error("status not cleared by read");

  chk_read_data_once: assert property (
    !regRead |=> (regRdData == 8'h00))
    else $error("read data present without a read");

  // a write to the enable register copies bit 6
  chk_enable_write: assert property (
    (regWrite && hitEnables) |=> (st.enableBit == $past(regWrData[6])))
    else $error("enable bit not written");

  // the enable bit moves only on its own write
  chk_enable_holds: assert property (
    !(regWrite && hitEnables) |=> $stable(st.enableBit))
    else $error("enable bit changed without a write");

  // software may set the flag by writing a one
  chk_flag_write_set: assert property (
    (regWrite && hitFlags && regWrData[6]) |=> st.flagBit)
    else $error("flag not set by write of one");

  // without an event or a write the flag keeps its value
  chk_flag_holds: assert property (
    (!cmpChange && !(regWrite && hitFlags)) |=> $stable(st.flagBit))
    else $error("flag changed on its own");

  // an event beside a clearing write must not be lost
  chk_flag_set_wins: assert property (
    (cmpChange && regWrite && hitFlags) |=> st.flagBit)
    else $error("event lost to a same-cycle write");

  // the individual enable off does not stop the flag
  chk_flag_enable_off: assert property (
    (cmpChange && !st.enableBit && st.globalEn) |=> st.flagBit)
    else $error("flag gated by its enable");

  // writes elsewhere leave the flag alone
  chk_flag_addr_only: assert property (
    (regWrite && !hitFlags && !cmpChange) |=> $stable(st.flagBit))
    else $error("flag changed by a write elsewhere");

  // no request while the global enable is off
  chk_irq_needs_gie: assert property (
    !st.globalEn |=> !cmpIrqReq)
    else $error("request without global enable");

  // no request while the individual enable is off
  chk_irq_needs_enable: assert property (
    !st.enableBit |=> !cmpIrqReq)
    else $error("request without its enable");

  // no request while the flag is clear
  chk_irq_needs_flag: assert property (
    !st.flagBit |=> !cmpIrqReq)
    else $error("request without the flag");

  // the unused bits of the flag register read as zero
  chk_flag_upper_zero: assert property (
    (regRead && hitFlags) |=> (regRdData[7] == 1'b0 && regRdData[5:0] == 6'h00))
    else $error("unused flag bits not zero");

  // a write to the control register copies bit 7
  chk_gie_write: assert property (
    (regWrite && hitControl) |=> (st.globalEn == $past(regWrData[7])))
    else $error("global enable not written");

  // the global enable moves only on its own write
  chk_gie_holds: assert property (
    !(regWrite && hitControl) |=> $stable(st.globalEn))
    else $error("global enable changed without a write");

  // every change pulse marks the sticky status
  chk_status_sets: assert property (
    cmpChange |=> st.evtStatus)
    else $error("status not set by an event");

  // the status moves only on an event or its own read
  chk_status_holds: assert property (
    (!cmpChange && !(regRead && hitStatus)) |=> $stable(st.evtStatus))
    else $error("status changed on its own");

  // a status read returns the value before the clear
  chk_status_readback: assert property (
    (regRead && hitStatus) |=> (regRdData == {7'h00, $past(st.evtStatus)}))
    else $error("status read back wrong");

  // the level interrupt follows status and mask one cycle later
  chk_irqout_gating: assert property (
    ##1 (irqOut == ($past(st.evtStatus) && $past(st.evtMask))))
    else $error("event interrupt does not follow its gate");

  // a masked status never drives the line
  chk_irqout_needs_mask: assert property (
    !st.evtMask |=> !irqOut)
    else $error("event interrupt while masked");

  // unmapped addresses answer zero
  chk_unmapped_read: assert property (
    (regRead && !hitFlags && !hitEnables && !hitControl && !hitStatus && !hitMask) |=> (regRdData == 8'h00))
    else $error("unmapped read not zero");

  // a write to the mask register copies bit 0
  chk_mask_write: assert property (
    (regWrite && hitMask) |=> (st.evtMask == $past(regWrData[0])))
    else $error("mask not written");

  // the mask moves only on its own write
  chk_mask_holds: assert property (
    !(regWrite && hitMask) |=> $stable(st.evtMask))
    else $error("mask changed without a write");

  // the mask reads back at bit 0
  chk_mask_readback: assert property (
    (regRead && hitMask) |=> (regRdData == {7'h00, $past(st.evtMask)}))
    else $error("mask read back wrong");

  // the global enable reads back at bit 7
  chk_control_readback: assert property (
    (regRead && hitControl) |=> (regRdData == {$past(st.globalEn), 7'h00}))
    else $error("control read back wrong");

endmodule

// *** verification/cmpirq_regs_tb.sv ***
// Purpose: self-checking bench for the comparator interrupt registers
// Assumes: read data stand only in the cycle after the read strobe
// Notes: flag is cleared before its enable is set, so no stale request fires
`timescale 1ns/10ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cmpirq_regs_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic cmpChange = 1'b0;
  logic [7:0] regRdData;
  logic cmpIrqReq;
  logic irqOut;
  logic [7:0] rd;
  int failures = 0;
  int testsRun = 0;
  cmpirq_regs u_cmpirq_regs (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cmpChange(cmpChange),
    .cmpIrqReq(cmpIrqReq), .irqOut(irqOut));
  // 100 ns period
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic wrreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // data sampled mid-cycle, the only cycle they stand
  task automatic rdreg(input logic [7:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    rd = regRdData;
  endtask
  task automatic pulse();
    @(posedge core_clk);
    cmpChange <= 1'b1;
    @(posedge core_clk);
    cmpChange <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about 52 cycles
  initial begin
    #(2000 * 100);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS);
    `CHK(rd, 8'h00)
    rdreg(cmpirq_pkg::CMPIRQ_OFS_ENABLES);
    `CHK(rd, 8'h00)
    rdreg(8'h55);
    `CHK(rd, 8'h00)
    $display("test reset done");
    wrreg(cmpirq_pkg::CMPIRQ_OFS_ENABLES, 8'hff);
    rdreg(cmpirq_pkg::CMPIRQ_OFS_ENABLES);
    `CHK(rd, 8'h40)
    wrreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS, 8'hbf);
    rdreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS);
    `CHK(rd, 8'h00)
    $display("test fields done");
    // event with every enable off still sets the flag
    wrreg(cmpirq_pkg::CMPIRQ_OFS_ENABLES, 8'h00);
    pulse();
    rdreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS);
    `CHK(rd, 8'h40)
    wrreg(cmpirq_pkg::CMPIRQ_OFS_CONTROL, 8'h80);
    repeat (2) @(negedge core_clk);
    `CHK(cmpIrqReq, 1'b0)
    $display("test flag done");
    wrreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS, 8'h00);
    wrreg(cmpirq_pkg::CMPIRQ_OFS_ENABLES, 8'h40);
    rdreg(cmpirq_pkg::CMPIRQ_OFS_FLAGS);
    `CHK(rd, 8'h00)
    `CHK(cmpIrqReq, 1'b0)
    pulse();
    @(negedge core_clk);
    `CHK(cmpIrqReq, 1'b0)
    @(negedge core_clk);
    `CHK(cmpIrqReq, 1'b1)
    wrreg(cmpirq_pkg::CMPIRQ_OFS_CONTROL, 8'h00);
    repeat (2) @(negedge core_clk);
    `CHK(cmpIrqReq, 1'b0)
    $display("test request done");
    // sticky status, cleared by its own read
    rdreg(cmpirq_pkg::CMPIRQ_OFS_EVT_STATUS);
    `CHK(rd, 8'h01)
    wrreg(cmpirq_pkg::CMPIRQ_OFS_EVT_MASK, 8'h01);
    repeat (2) @(negedge core_clk);
    `CHK(irqOut, 1'b0)
    pulse();
    repeat (2) @(negedge core_clk);
    `CHK(irqOut, 1'b1)
    rdreg(cmpirq_pkg::CMPIRQ_OFS_EVT_STATUS);
    `CHK(rd, 8'h01)
    rdreg(cmpirq_pkg::CMPIRQ_OFS_EVT_STATUS);
    `CHK(rd, 8'h00)
    `CHK(irqOut, 1'b0)
    $display("test status done");
    tally_and_finish();
  end
endmodule
